// ### wmcat_defs.svh
// Timing constants and rule overview for the channel-access timing block
// Overview of operation
// - Interframe-space timers start when the PHY reports the medium has gone quiet.
// - Interframe-space timers support RIFS as well as SIFS and AIFS spacings.
// - Interframe-space timers pulse the transmit engine with a precise start trigger.
// - One independent backoff engine per WMM access category.
// - Each backoff engine samples the medium every slot, then counts or holds.
// - A backoff counter reaching zero notifies the transmit engine.
// - Simultaneous zero counters: exactly one granted by sequencer-programmed policy.
// - Transmit engine starts a scheduled frame only on the interframe-space trigger.
// - Power save gates the MAC clock; slow-clock sleep timer sets the duration.
// - On sleep timer expiry the clock is ungated and suspension ends.
// - A free-running TSF timer and its derived target beacon time are kept.
// - Sequencer may load TSF with a received beacon or probe timestamp.
// - Trigger pulses fire when TSF reaches programmed offsets.
// - Sequencer loads NAV from the duration field of received frames.
// - NAV state feeds the interframe-space unit as virtual carrier sense.
`ifndef WMCAT_DEFS_SVH
`define WMCAT_DEFS_SVH
`define WMCAT_CLK_MHZ 50
`define WMCAT_US_NS 1000
`define WMCAT_CLK_NS 20
`define WMCAT_US_CYC (`WMCAT_US_NS / `WMCAT_CLK_NS)
`define WMCAT_SLOT_US 9
`define WMCAT_SIFS_US 16
`define WMCAT_RIFS_US 2
`define WMCAT_NUM_AC 4
`define WMCAT_TSF_RST 64'h0000000000000000
`define WMCAT_NAV_RST 16'h0000
`endif

// ### wmcat_phy_model.sv
// PHY carrier-sense model driving activity bursts
`timescale 1ns/1ps
`default_nettype none
module wmcat_phy_model (
  // Clock, reset and burst request
  input wire logic mclk,
  input wire logic rst,
  input wire logic burst_go,
  input wire logic [15:0] burst_len,
  // Carrier indication
  output logic phy_cca
);
  logic [15:0] left_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) left_q <= 16'h0000;
    else left_q <= burst_go ? burst_len : left_q - 16'(left_q != 16'h0000);
  end
  // One clean falling edge ends each burst
  assign phy_cca = (left_q != 16'h0000);
endmodule
`default_nettype wire

// ### wmcat_pkg.sv
// Types for the channel-access timing block
package wmcat_pkg;
  typedef enum logic [1:0] {WMCAT_IFS_SIFS, WMCAT_IFS_RIFS, WMCAT_IFS_AIFS} wmcat_ifs_t;
  typedef enum logic {WMCAT_ARB_FIXED, WMCAT_ARB_RR} wmcat_arb_t;
  typedef struct packed {
    logic start;
    wmcat_ifs_t kind;
    logic [7:0] aifs_slots;
  } wmcat_ifs_cmd_t;
  typedef struct packed {
    logic load;
    logic [1:0] ac;
    logic [9:0] count;
  } wmcat_bo_cmd_t;
endpackage

// ### wmcat_timing.sv
// Channel-access timing: INTERFRAME_SPACING_UNIT, backoff, NAV, TSF, sleep control
`timescale 1ns/1ps
`default_nettype none
`include "wmcat_defs.svh"
module wmcat_timing
  import wmcat_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // PHY carrier indication, asynchronous
  input wire logic phy_cca,
  // Slow clock for sleep timing, asynchronous
  input wire logic slow_clk,
  // Sequencer control
  input wire wmcat_ifs_cmd_t ifs_cmd,
  input wire wmcat_bo_cmd_t bo_cmd,
  input wire wmcat_arb_t arb_mode,
  input wire logic nav_load,
  input wire logic [15:0] nav_duration,
  input wire logic tsf_load,
  input wire logic [63:0] tsf_value,
  input wire logic [31:0] bcn_interval,
  input wire logic [63:0] evt_offset0,
  input wire logic [63:0] evt_offset1,
  input wire logic sleep_req,
  input wire logic [31:0] sleep_count,
  // Transmit engine and status
  output logic ifs_trigger_q,
  output logic bo_grant_q,
  output logic [1:0] bo_grant_ac_q,
  output logic [3:0] bo_pending_q,
  output logic medium_busy_q,
  output logic [15:0] nav_q,
  output logic [63:0] tsf_q,
  output logic tbtt_q,
  output logic [1:0] evt_trig_q,
  output logic mac_clk_en_q,
  output logic sleeping_q
);
  localparam int NAC = `WMCAT_NUM_AC;
  localparam logic [5:0] US_CYC = 6'(`WMCAT_US_CYC);

  function automatic logic [15:0] us_to_cyc(input logic [7:0] us);
    us_to_cyc = 16'(us) * 16'(US_CYC);
  endfunction

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  logic cca_s1_q, cca_s2_q, slw_s1_q, slw_s2_q, slw_s3_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cca_s1_q <= 1'b0;
      cca_s2_q <= 1'b0;
      slw_s1_q <= 1'b0;
      slw_s2_q <= 1'b0;
      slw_s3_q <= 1'b0;
    end else begin
      cca_s1_q <= phy_cca;
      cca_s2_q <= cca_s1_q;
      slw_s1_q <= slow_clk;
      slw_s2_q <= slw_s1_q;
      slw_s3_q <= slw_s2_q;
    end
  end
  wire slow_tick = slw_s2_q & ~slw_s3_q;

  // --------------------------------------------------------------
  // Microsecond tick and NAV
  // --------------------------------------------------------------
  logic [5:0] us_cnt_q;
  wire us_tick = (us_cnt_q == US_CYC - 6'h01);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) us_cnt_q <= 6'h00;
    else us_cnt_q <= us_tick ? 6'h00 : us_cnt_q + 6'h01;
  end

  wire nav_take = nav_load && (nav_duration > nav_q);
  wire [15:0] nav_d = nav_take ? nav_duration :
                      (us_tick && nav_q != 16'h0000) ? nav_q - 16'h0001 : nav_q;
  // Virtual and physical carrier sense combined
  wire busy_d = cca_s2_q | (nav_d != 16'h0000);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nav_q <= `WMCAT_NAV_RST;
      medium_busy_q <= 1'b1;
    end else begin
      nav_q <= nav_d;
      medium_busy_q <= busy_d;
    end
  end

  // --------------------------------------------------------------
  // Interframe-space timer
  // --------------------------------------------------------------
  localparam logic [15:0] SLOT_CYC = 16'(`WMCAT_SLOT_US * `WMCAT_US_CYC);
  logic busy_prev_q, ifs_run_q;
  logic [15:0] ifs_cnt_q, ifs_len_q;
  wire idle_edge = busy_prev_q & ~medium_busy_q;
  wire [15:0] ifs_len_d = (ifs_cmd.kind == WMCAT_IFS_RIFS) ? us_to_cyc(8'(`WMCAT_RIFS_US)) :
    (ifs_cmd.kind == WMCAT_IFS_AIFS) ?
    16'(us_to_cyc(8'(`WMCAT_SIFS_US)) + 16'(ifs_cmd.aifs_slots) * SLOT_CYC) :
    us_to_cyc(8'(`WMCAT_SIFS_US));
  logic armed_q;
  wire ifs_done = ifs_run_q && (ifs_cnt_q + 16'h0001 >= ifs_len_q);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_prev_q <= 1'b1;
      armed_q <= 1'b0;
      ifs_run_q <= 1'b0;
      ifs_cnt_q <= 16'h0000;
      ifs_len_q <= 16'h0000;
      ifs_trigger_q <= 1'b0;
    end else begin
      busy_prev_q <= medium_busy_q;
      if (ifs_cmd.start) begin
        armed_q <= 1'b1;
        ifs_len_q <= ifs_len_d;
      end
      ifs_trigger_q <= 1'b0;
      if (medium_busy_q) begin
        ifs_run_q <= 1'b0;
      end else if (idle_edge && (armed_q || ifs_cmd.start)) begin
        ifs_run_q <= 1'b1;
        ifs_cnt_q <= 16'h0000;
      end else if (ifs_done) begin
        ifs_run_q <= 1'b0;
        // A fresh start in the same cycle keeps the timer armed
        if (!ifs_cmd.start) armed_q <= 1'b0;
        ifs_trigger_q <= 1'b1;
      end else if (ifs_run_q) begin
        ifs_cnt_q <= ifs_cnt_q + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------
  // Backoff engines, one per access category
  // --------------------------------------------------------------
  logic [15:0] slot_cnt_q;
  logic slot_busy_q;
  wire slot_end = (slot_cnt_q == SLOT_CYC - 16'h0001);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slot_cnt_q <= 16'h0000;
      slot_busy_q <= 1'b0;
    end else begin
      slot_cnt_q <= slot_end ? 16'h0000 : slot_cnt_q + 16'h0001;
      // Busy at any point in the slot spoils the whole slot
      slot_busy_q <= slot_end ? 1'b0 : (slot_busy_q | medium_busy_q);
    end
  end
  wire slot_idle = slot_end && !slot_busy_q && !medium_busy_q;

  logic [9:0] bo_cnt_q [NAC];
  logic [NAC-1:0] bo_act_q;
  logic [NAC-1:0] bo_zero;
  logic [1:0] rr_q;
  for (genvar i = 0; i < NAC; i++) begin : g_bo
    assign bo_zero[i] = bo_act_q[i] && (bo_cnt_q[i] == 10'h000);
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        bo_cnt_q[i] <= 10'h000;
        bo_act_q[i] <= 1'b0;
      end else if (bo_cmd.load && bo_cmd.ac == 2'(i)) begin
        bo_cnt_q[i] <= bo_cmd.count;
        bo_act_q[i] <= 1'b1;
      end else if (bo_grant_q && bo_grant_ac_q == 2'(i)) begin
        bo_act_q[i] <= 1'b0;
      end else if (slot_idle && bo_act_q[i] && bo_cnt_q[i] != 10'h000) begin
        bo_cnt_q[i] <= bo_cnt_q[i] - 10'h001;
      end
    end
  end

  // Fixed mode favours the highest category; round robin avoids starving low ones
  function automatic logic [1:0] pick(input logic [3:0] req, input logic [1:0] start);
    logic [1:0] k;
    pick = start;
    for (int j = NAC - 1; j >= 0; j--) begin
      k = 2'(start + 2'(j));
      if (req[k]) pick = k;
    end
  endfunction
  wire [1:0] fix_sel = bo_zero[3] ? 2'h3 : bo_zero[2] ? 2'h2 : bo_zero[1] ? 2'h1 : 2'h0;
  wire [1:0] win = (arb_mode == WMCAT_ARB_RR) ? pick(bo_zero, rr_q) : fix_sel;
  wire any_zero = |bo_zero;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bo_grant_q <= 1'b0;
      bo_grant_ac_q <= 2'h0;
      bo_pending_q <= 4'h0;
      rr_q <= 2'h0;
    end else begin
      bo_pending_q <= bo_zero;
      bo_grant_q <= any_zero && !bo_grant_q;
      if (any_zero && !bo_grant_q) begin
        bo_grant_ac_q <= win;
        rr_q <= 2'(win + 2'h1);
      end
    end
  end

  // --------------------------------------------------------------
  // TSF, beacon time and offset events
  // --------------------------------------------------------------
  logic [63:0] next_tbtt_q;
  // Zero interval would divide by zero; TBTT is disabled then anyway
  wire [63:0] bcn_div = (bcn_interval == 32'h0) ? 64'h1 : 64'(bcn_interval);
  wire [63:0] tsf_d = tsf_load ? tsf_value : (us_tick ? tsf_q + 64'h1 : tsf_q);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tsf_q <= `WMCAT_TSF_RST;
      next_tbtt_q <= `WMCAT_TSF_RST;
      tbtt_q <= 1'b0;
      evt_trig_q <= 2'h0;
    end else begin
      tsf_q <= tsf_d;
      tbtt_q <= 1'b0;
      if (tsf_load) begin
        next_tbtt_q <= tsf_value + 64'(bcn_interval) - (tsf_value % bcn_div);
      end else if (bcn_interval != 32'h0 && tsf_d == next_tbtt_q && tsf_d != tsf_q) begin
        tbtt_q <= 1'b1;
        next_tbtt_q <= next_tbtt_q + 64'(bcn_interval);
      end
      evt_trig_q[0] <= (tsf_d == evt_offset0) && (tsf_d != tsf_q);
      evt_trig_q[1] <= (tsf_d == evt_offset1) && (tsf_d != tsf_q);
    end
  end

  // --------------------------------------------------------------
  // Sleep timer on slow-clock edges
  // --------------------------------------------------------------
  logic [31:0] sleep_cnt_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleep_cnt_q <= 32'h0;
      sleeping_q <= 1'b0;
      mac_clk_en_q <= 1'b1;
    end else if (!sleeping_q) begin
      if (sleep_req && sleep_count != 32'h0) begin
        sleep_cnt_q <= sleep_count;
        sleeping_q <= 1'b1;
        mac_clk_en_q <= 1'b0;
      end
    end else if (slow_tick) begin
      if (sleep_cnt_q == 32'h1) begin
        sleeping_q <= 1'b0;
        mac_clk_en_q <= 1'b1;
      end
      sleep_cnt_q <= sleep_cnt_q - 32'h1;
    end
  end
endmodule
`default_nettype wire

// ### wmcat_timing_assertions.sv
// Concurrent checks on the channel-access timing ports
`timescale 1ns/1ps
`default_nettype none
module wmcat_timing_assertions
  import wmcat_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Inputs
  input wire logic phy_cca,
  input wire logic nav_load,
  input wire logic [15:0] nav_duration,
  input wire logic tsf_load,
  input wire logic [63:0] tsf_value,
  // Outputs
  input wire logic ifs_trigger_q,
  input wire logic bo_grant_q,
  input wire logic [1:0] bo_grant_ac_q,
  input wire logic medium_busy_q,
  input wire logic [15:0] nav_q,
  input wire logic [63:0] tsf_q,
  input wire logic mac_clk_en_q,
  input wire logic sleeping_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Shortest spacing is far longer than eight cycles
  sequence s_quiet; !ifs_trigger_q [*8]; endsequence
  property p_gap; $fell(medium_busy_q) |-> s_quiet; endproperty
  a_gap: assert property (p_gap) else $error("early trigger");
  property p_cca; phy_cca [*4] |=> medium_busy_q; endproperty
  a_cca: assert property (p_cca) else $error("busy missed");
  property p_navb; nav_q != 16'h0000 && $past(nav_q) != 16'h0000 |-> medium_busy_q; endproperty
  a_navb: assert property (p_navb) else $error("nav not busy");
  property p_nvld; nav_load && nav_duration > nav_q |=> nav_q == $past(nav_duration); endproperty
  a_nvld: assert property (p_nvld) else $error("nav not taken");
  property p_nvkp;
    !(nav_load && nav_duration > nav_q) && nav_q != 16'h0000
      |=> nav_q == $past(nav_q) || nav_q == $past(nav_q) - 16'h0001;
  endproperty
  a_nvkp: assert property (p_nvkp) else $error("nav step wrong");
  property p_tsld; tsf_load |=> tsf_q == $past(tsf_value); endproperty
  a_tsld: assert property (p_tsld) else $error("tsf load wrong");
  property p_tsrn; !tsf_load |=> tsf_q - $past(tsf_q) <= 64'h1; endproperty
  a_tsrn: assert property (p_tsrn) else $error("tsf jump");
  property p_gpls; bo_grant_q |=> !bo_grant_q; endproperty
  a_gpls: assert property (p_gpls) else $error("grant too long");
  property p_gac; !bo_grant_q |-> $stable(bo_grant_ac_q); endproperty
  a_gac: assert property (p_gac) else $error("grant ac moved");
  property p_gate; sleeping_q |-> !mac_clk_en_q; endproperty
  a_gate: assert property (p_gate) else $error("clock on in sleep");
  property p_wake; $fell(sleeping_q) |-> mac_clk_en_q; endproperty
  a_wake: assert property (p_wake) else $error("no ungate");
endmodule
bind wmcat_timing wmcat_timing_assertions i_chk (.mclk, .rst, .phy_cca, .nav_load,
  .nav_duration, .tsf_load, .tsf_value, .ifs_trigger_q, .bo_grant_q, .bo_grant_ac_q,
  .medium_busy_q, .nav_q, .tsf_q, .mac_clk_en_q, .sleeping_q);
`default_nettype wire

// ### wmcat_timing_tb.sv
// Self-checking bench for the channel-access timing block
`timescale 1ns/1ps
`default_nettype none
`include "wmcat_defs.svh"
module wmcat_timing_tb;
  import wmcat_pkg::*;
  localparam int US = `WMCAT_US_CYC;
  localparam int SLOT = `WMCAT_SLOT_US * US;
  logic mclk = 1'b0, rst = 1'b1, slow_clk = 1'b0;
  logic nav_load, tsf_load, sleep_req, burst_go, phy_cca, ifs_trigger_q, bo_grant_q, tbtt_q;
  logic medium_busy_q, mac_clk_en_q, sleeping_q;
  wmcat_ifs_cmd_t ifs_cmd;
  wmcat_bo_cmd_t bo_cmd;
  wmcat_arb_t arb_mode;
  logic [15:0] nav_duration, burst_len, nav_q, d;
  logic [63:0] tsf_value, evt_offset0, evt_offset1, tsf_q, v, b;
  logic [31:0] sleep_count, bcn_interval;
  logic [1:0] bo_grant_ac_q, evt_trig_q, a;
  logic [3:0] bo_pending_q;
  int bad_count = 0, compares = 0, n, lo;
  always #10 mclk = ~mclk;
  always #500 slow_clk = ~slow_clk;
  wmcat_timing i_dut (.mclk, .rst, .phy_cca, .slow_clk, .ifs_cmd, .bo_cmd, .arb_mode, .nav_load,
    .nav_duration, .tsf_load, .tsf_value, .bcn_interval, .evt_offset0, .evt_offset1, .sleep_req,
    .sleep_count, .ifs_trigger_q, .bo_grant_q, .bo_grant_ac_q, .bo_pending_q, .medium_busy_q,
    .nav_q, .tsf_q, .tbtt_q, .evt_trig_q, .mac_clk_en_q, .sleeping_q);
  wmcat_phy_model i_phy (.mclk, .rst, .burst_go, .burst_len, .phy_cca);
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic rng(input int l, input int h);
    chk(n >= l && n <= h, 1'b1);
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return bo_grant_q;
      1: return ifs_trigger_q;
      2: return evt_trig_q[0];
      3: return !sleeping_q;
      4: return evt_trig_q[1];
      default: return tbtt_q;
    endcase
  endfunction
  function automatic int ifs_cyc(input int k, input int s);
    if (k == 1) return `WMCAT_RIFS_US * US;
    return `WMCAT_SIFS_US * US + (k == 2 ? s * SLOT : 0);
  endfunction
  task automatic final_report;
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait; running out ends the run
  task automatic wait_on(input int w, input int lim);
    for (n = 0; n < lim && sig(w) !== 1'b1; n++) cyc(1);
    if (n == lim) begin
      bad_count++;
      $display("BAD %0t wait %0d", $time, w);
      final_report();
    end
  endtask
  initial begin
    {nav_load, tsf_load, sleep_req, burst_go, ifs_cmd, bo_cmd} = '0;
    {nav_duration, burst_len, tsf_value, sleep_count} = '0;
    {evt_offset0, evt_offset1} = '1;
    arb_mode = WMCAT_ARB_FIXED;
    bcn_interval = 32'h00000064;
    void'($urandom(32'h263400DB));
    cyc(8);
    chk({medium_busy_q, mac_clk_en_q, nav_q}, 18'h30000);
    rst = 1'b0;
    cyc(4);
    for (int k = 0; k < 3; k++) begin
      {burst_go, burst_len} = {1'b1, 16'h001E};
      cyc(1);
      burst_go = 1'b0;
      cyc(4);
      ifs_cmd = '{1'b1, wmcat_ifs_t'(k), 8'($urandom_range(1, 3))};
      cyc(1);
      ifs_cmd.start = 1'b0;
      cyc(25);
      wait_on(1, 3000);
      lo = ifs_cyc(k, ifs_cmd.aifs_slots);
      rng(lo - 2, lo + 8);
      $display("spacing %0d done", k);
    end
    for (int k = 0; k < 2; k++) begin
      d = 16'($urandom_range(20, 60));
      bo_cmd = '{1'b1, 2'($urandom), 10'($urandom_range(1, 3))};
      if (k == 0) {burst_go, burst_len} = {1'b1, 16'(d * US)};
      else {nav_load, nav_duration} = {1'b1, d};
      cyc(1);
      {burst_go, nav_load, bo_cmd.load} = 3'h0;
      if (k == 1) begin
        chk(nav_q, d);
        {nav_load, nav_duration} = {1'b1, d - 16'h0005};
        cyc(1);
        nav_load = 1'b0;
        chk(nav_q == d || nav_q == d - 16'h0001, 1'b1);
      end
      wait_on(0, 6000);
      lo = (d - 1) * US + bo_cmd.count * SLOT;
      rng(lo, lo + US + SLOT + 12);
      chk(bo_grant_ac_q, bo_cmd.ac);
      $display("backoff hold %0d done", k);
    end
    for (int m = 0; m < 2; m++) begin
      arb_mode = wmcat_arb_t'(m);
      bo_cmd = '{1'b1, 2'h0, 10'h002};
      cyc(1);
      bo_cmd.ac = 2'h3;
      cyc(1);
      bo_cmd.load = 1'b0;
      wait_on(0, 2000);
      chk(bo_pending_q, 4'h9);
      a = bo_grant_ac_q;
      cyc(1);
      wait_on(0, 20);
      chk(bo_grant_ac_q != a, 1'b1);
      if (m == 0) chk(a, 2'h3);
      $display("arbitration %0d done", m);
    end
    v = {$urandom, $urandom} >> 2;
    {tsf_load, tsf_value, evt_offset0, evt_offset1} = {1'b1, v, v + 64'h3, v + 64'h5};
    cyc(1);
    tsf_load = 1'b0;
    chk(tsf_q, v);
    wait_on(2, 400);
    rng(2 * US - 2, 3 * US + 4);
    chk(tsf_q, v + 64'h3);
    wait_on(4, 400);
    rng(2 * US - 1, 2 * US + 1);
    b = v + 64'(bcn_interval) - v % 64'(bcn_interval);
    if (b < tsf_q) b = b + 64'(bcn_interval);
    wait_on(5, 6000);
    chk(tsf_q, b);
    $display("tsf done");
    for (int k = 0; k < 2; k++) begin
      {sleep_req, sleep_count} = {1'b1, 32'(k * $urandom_range(2, 4))};
      cyc(1);
      sleep_req = 1'b0;
      cyc(3);
      chk({sleeping_q, mac_clk_en_q}, k ? 2'h2 : 2'h1);
    end
    wait_on(3, 400);
    rng(int'(sleep_count - 1) * 50 - 8, int'(sleep_count) * 50 + 10);
    chk(mac_clk_en_q, 1'b1);
    {tsf_load, tsf_value} = {1'b1, tsf_q + 64'(sleep_count)};
    cyc(1);
    tsf_load = 1'b0;
    chk(tsf_q, tsf_value);
    $display("sleep done");
    final_report();
  end
endmodule
`default_nettype wire
